//--- rtl/pls_unit.sv
`timescale 1ns/1ps
// Overview of operation
// - slices 0-2: two tables, two registers
// - slice 3: two tables, combinational only
// - registers rising, falling or latch
// - set/reset selectable sync or async
// - clock, chip select, wide join logic
// - slices 0-2: 14 in, 7 out
// - slice 3: 10 in, 4 out
// - each table holds sixteen entries
// - two tables join into five inputs
// - wider functions join several slices
// - memory only in slices 0,2, capable unit
// - ripple add, subtract, dynamic choice
// - ripple counters with clear, preload
// - ripple compare, multiplier step
// - fast carry in and out chain
// - memory tables form 16x4 single port
// - slice 1 gives address and write
// - 16x2 pseudo dual port pairing
// - all slices hold loaded read-only tables
// - unselected select mux outputs one
module pls_unit
  import pls_pkg::*;
#(
  parameter bit RAM_CAPABLE = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire pls_in_t [3:0] route_i,
  input wire logic carry_in_i,
  input wire logic wide_i,
  output pls_out_t [3:0] route_o,
  output logic carry_out_o,
  output logic seven_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pls_cfg_t cfg_r [PLS_NSLICE]; // slice configs
  logic pseudo_dual_port_ram_r; // pseudo dual port pairing
  logic ack_r; // bus answer
  logic [31:0] dat_r; // read data
  logic hit_w; // new bus cycle
  logic wr_w; // bus write
  logic [1:0] sl_w; // addressed slice
  logic [7:0] ofs_w; // offset in slice
  logic blk_w; // slice block hit
  logic [2:0] cks1_r; // clock sync stage 1
  logic [2:0] cks2_r; // clock sync stage 2
  logic [2:0] cks3_r; // clock sync stage 3
  logic [2:0] ckl_r; // agreed clock level
  logic [2:0] ckp_r; // previous level
  logic [2:0] ck_raw_w; // selected clocks
  logic [2:0] rise_w; // rising events
  logic [2:0] fall_w; // falling events
  logic ram_wr_w; // memory write strobe
  logic [3:0] ram_adr_w; // memory write address
  wire [15:0] truth_w [PLS_NSLICE][2]; // table contents
  wire [1:0] f_w [PLS_NSLICE]; // table outputs
  wire [1:0] q_w [PLS_NSLICE]; // register outputs
  wire [1:0] ofx_w [PLS_NSLICE]; // wide outputs
  wire five_w [PLS_NSLICE]; // five input results
  wire [3:0] stat_w [PLS_NSLICE]; // compare, carry
  wire [PLS_NREG:0] cin_w; // carry chain
  wire six01_w; // six input, slices 0/1
  wire six23_w; // six input, slices 2/3
  wire seven_w; // seven input
  wire eight_w; // eight input

  // byte lane merge for writes
  function automatic logic [31:0] merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0] sel
  );
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
      begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // wishbone slave
  // ----------------------------------------
  assign hit_w = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_w = hit_w && wb_we_i;
  assign blk_w = (wb_adr_i[7:6] == 2'b00);
  assign sl_w = wb_adr_i[5:4];
  assign ofs_w = {4'h0, wb_adr_i[3:0]};

  // one cycle answer to every cycle, mapped or not
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_r <= 1'b0;
    end
    else
    begin
      ack_r <= hit_w;
    end
  end

  // configuration registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int s = 0; s < PLS_NSLICE; s++)
      begin
        cfg_r[s] <= PLS_CFG_RST;
      end
    end
    else if (wr_w && blk_w && ofs_w == PLS_OFS_CFG)
    begin
      cfg_r[sl_w] <= merge(cfg_r[sl_w], wb_dat_i, wb_sel_i);
    end
  end

  // unit control register
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pseudo_dual_port_ram_r <= PLS_UNIT_RST;
    end
    else if (wr_w && wb_adr_i == PLS_OFS_UNIT && wb_sel_i[0])
    begin
      pseudo_dual_port_ram_r <= wb_dat_i[0];
    end
  end

  // read data, unmapped reads give zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dat_r <= 32'h0000_0000;
    end
    else if (hit_w && !wb_we_i)
    begin
      if (blk_w && ofs_w == PLS_OFS_TRUTH)
      begin
        dat_r <= {truth_w[sl_w][1], truth_w[sl_w][0]};
      end
      else if (blk_w && ofs_w == PLS_OFS_CFG)
      begin
        dat_r <= cfg_r[sl_w];
      end
      else if (blk_w && ofs_w == PLS_OFS_STAT)
      begin
        dat_r <= {22'h0, stat_w[sl_w], ofx_w[sl_w],
                  q_w[sl_w], f_w[sl_w]};
      end
      else if (wb_adr_i == PLS_OFS_UNIT)
      begin
        dat_r <= {31'h0, pseudo_dual_port_ram_r};
      end
      else
      begin
        dat_r <= 32'h0000_0000;
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  // ----------------------------------------
  // slice clock selection and sync
  // ----------------------------------------
  // unselected clock mux stays at one
  always_comb
  begin
    for (int s = 0; s < PLS_NREG; s++)
    begin
      ck_raw_w[s] = cfg_r[s].clk_sel ? route_i[s].clk : 1'b1;
    end
  end

  // three stages, level moves once 2 and 3 agree
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cks1_r <= 3'h7;
      cks2_r <= 3'h7;
      cks3_r <= 3'h7;
      ckl_r <= 3'h7;
      ckp_r <= 3'h7;
    end
    else
    begin
      cks1_r <= ck_raw_w;
      cks2_r <= cks1_r;
      cks3_r <= cks2_r;
      ckl_r <= (cks2_r & cks3_r) | (ckl_r & (cks2_r ^ cks3_r));
      ckp_r <= ckl_r;
    end
  end

  assign rise_w = ckl_r & ~ckp_r;
  assign fall_w = ~ckl_r & ckp_r;

  // ----------------------------------------
  // distributed memory control
  // ----------------------------------------
  // slice 1 lends address and write enable
  assign ram_adr_w = {route_i[1].d[0], route_i[1].c[0],
                      route_i[1].b[0], route_i[1].a[0]};
  assign ram_wr_w = route_i[1].m[0] &&
                    (cfg_r[1].ce_sel ? route_i[1].ce : 1'b1);

  assign cin_w[0] = carry_in_i;

  // ----------------------------------------
  // slices
  // ----------------------------------------
  for (genvar s = 0; s < PLS_NSLICE; s++)
  begin : g_slice
    pls_mode_t mode_w; // effective mode
    logic ram_w; // memory mode active
    logic rip_w; // ripple mode active
    logic [31:0] cfg_d_w; // merged table load word
    logic cfg_we_w; // table load
    logic [1:0] wd_w; // memory write data
    logic [1:0] op_a_w; // operand a
    logic [1:0] op_b_w; // effective b
    logic [2:0] sum_w; // sum with carry
    logic [2:0] cmp_w; // a minus b
    logic ge_w; // a >= b
    logic ne_w; // a != b
    logic le_w; // a <= b

    // memory only in slices 0 and 2 of capable units
    always_comb
    begin
      mode_w = cfg_r[s].mode;
      if (mode_w == PLS_RAM && (!RAM_CAPABLE || s % 2 == 1))
      begin
        mode_w = PLS_LOGIC;
      end
      else if (mode_w == PLS_RIPPLE && s == PLS_NREG)
      begin
        mode_w = PLS_LOGIC;
      end
    end
    assign ram_w = (mode_w == PLS_RAM);
    assign rip_w = (mode_w == PLS_RIPPLE);

    // truth table load over the bus
    assign cfg_we_w = wr_w && blk_w && sl_w == 2'(s) &&
                      ofs_w == PLS_OFS_TRUTH;
    assign cfg_d_w = merge({truth_w[s][1], truth_w[s][0]},
                           wb_dat_i, wb_sel_i);

    // read-only companion mirrors slice 0 writes
    assign wd_w = (pseudo_dual_port_ram_r && s == 2) ? route_i[0].m :
                  route_i[s].m;

    // two tables per slice
    for (genvar k = 0; k < 2; k++)
    begin : g_tab
      logic [15:0] td_w; // load data for this table
      assign td_w = k == 0 ? cfg_d_w[15:0] : cfg_d_w[31:16];
      pls_table u_tab (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cfg_we_i(cfg_we_w),
        .cfg_d_i(td_w),
        .ram_we_i(ram_w && ram_wr_w),
        .ram_adr_i(ram_adr_w),
        .ram_d_i(wd_w[k]),
        .rd_adr_i({route_i[s].d[k], route_i[s].c[k],
                   route_i[s].b[k], route_i[s].a[k]}),
        .truth_o(truth_w[s][k]),
        .f_o()
      );
    end

    // ripple operands
    always_comb
    begin
      op_a_w = {route_i[s].a[1], route_i[s].a[0]};
      op_b_w = {route_i[s].b[1], route_i[s].b[0]};
      if (cfg_r[s].counter)
      begin
        op_a_w = q_w[s];
        op_b_w = 2'b00;
      end
      case (cfg_r[s].op)
        PLS_ADD: op_b_w = op_b_w;
        PLS_SUB: op_b_w = ~op_b_w;
        PLS_DYN: op_b_w = route_i[s].d[0] ? op_b_w : ~op_b_w;
        PLS_MUL: op_b_w = op_b_w & {2{route_i[s].m[1]}};
        default: op_b_w = op_b_w;
      endcase
    end

    // two bit adder with fast carry
    assign sum_w = {1'b0, op_a_w} + {1'b0, op_b_w} +
                   {2'b00, cin_w[s]};
    // compare a and b
    assign cmp_w = {1'b0, route_i[s].a} + {1'b0, ~route_i[s].b} +
                   3'h1;
    assign ge_w = cmp_w[2];
    assign ne_w = (route_i[s].a != route_i[s].b);
    assign le_w = !(ge_w && ne_w);

    if (s < PLS_NREG)
    begin : g_reg
      logic [1:0] d_w; // register data
      logic ce_w; // chip select mux
      logic lsr_w; // set/reset mux
      assign cin_w[s+1] = rip_w && sum_w[2];
      assign ce_w = cfg_r[s].ce_sel ? route_i[s].ce : 1'b1;
      assign lsr_w = cfg_r[s].lsr_en &&
                     (cfg_r[s].lsr_sel ? route_i[s].lsr : 1'b1);
      // preload from c inputs, else sum or table
      assign d_w = (rip_w && cfg_r[s].counter && route_i[s].m[0]) ?
                   {route_i[s].c[1], route_i[s].c[0]} :
                   rip_w ? sum_w[1:0] : f_w[s];
      for (genvar k = 0; k < 2; k++)
      begin : g_ff
        pls_sreg u_ff (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .rise_i(rise_w[s]),
          .fall_i(fall_w[s]),
          .lvl_i(ckl_r[s]),
          .cap_i(cfg_r[s].cap),
          .ce_i(ce_w),
          .lsr_i(lsr_w),
          .async_i(cfg_r[s].lsr_async),
          .lsr_val_i(cfg_r[s].lsr_val[k]),
          .d_i(d_w[k]),
          .q_o(q_w[s][k])
        );
      end
    end
    else
    begin : g_noreg
      assign q_w[s] = 2'b00;
    end

    // table outputs, sum bits in ripple mode
    assign f_w[s] = rip_w ? sum_w[1:0] :
                    {truth_w[s][1][{route_i[s].d[1], route_i[s].c[1],
                                    route_i[s].b[1], route_i[s].a[1]}],
                     truth_w[s][0][{route_i[s].d[0], route_i[s].c[0],
                                    route_i[s].b[0], route_i[s].a[0]}]};
    // join the two tables into five inputs
    assign five_w[s] = route_i[s].m[0] ? f_w[s][1] : f_w[s][0];
    assign stat_w[s] = {ne_w, le_w, ge_w, rip_w && sum_w[2]};
  end

  // ----------------------------------------
  // wide function join
  // ----------------------------------------
  assign six01_w = route_i[0].m[1] ? five_w[1] : five_w[0];
  assign six23_w = route_i[2].m[1] ? five_w[3] : five_w[2];
  assign seven_w = route_i[1].m[1] ? six23_w : six01_w;
  // eighth input joins a neighbour unit
  assign eight_w = route_i[3].m[1] ? wide_i : seven_w;

  assign ofx_w[0] = g_slice[0].rip_w ?
                    {g_slice[0].le_w, g_slice[0].ge_w} :
                    {six01_w, five_w[0]};
  assign ofx_w[1] = g_slice[1].rip_w ?
                    {g_slice[1].le_w, g_slice[1].ge_w} :
                    {seven_w, five_w[1]};
  assign ofx_w[2] = g_slice[2].rip_w ?
                    {g_slice[2].le_w, g_slice[2].ge_w} :
                    {six23_w, five_w[2]};
  assign ofx_w[3] = {eight_w, five_w[3]};

  // ----------------------------------------
  // routing outputs
  // ----------------------------------------
  always_comb
  begin
    for (int s = 0; s < PLS_NSLICE; s++)
    begin
      route_o[s].f = f_w[s];
      route_o[s].q = q_w[s];
      route_o[s].ofx = ofx_w[s];
    end
  end

  assign carry_out_o = cin_w[PLS_NREG];
  assign seven_o = seven_w;
endmodule

//--- rtl/pls_pkg.sv
// ----------------------------------------
// shared constants and carriers
// ----------------------------------------
package pls_pkg;
  // slice counts
  localparam int PLS_NSLICE = 4;
  localparam int PLS_NREG = 3;
  // register map, byte offsets
  localparam logic [7:0] PLS_OFS_TRUTH = 8'h00;
  localparam logic [7:0] PLS_OFS_CFG = 8'h04;
  localparam logic [7:0] PLS_OFS_STAT = 8'h08;
  localparam logic [7:0] PLS_OFS_UNIT = 8'h40;
  // reset values
  localparam logic [31:0] PLS_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] PLS_TRUTH_RST = 16'h0000;
  localparam logic PLS_UNIT_RST = 1'b0;
  // slice operating modes
  typedef enum logic [1:0] {
    PLS_LOGIC, PLS_RIPPLE, PLS_RAM, PLS_ROM
  } pls_mode_t;
  // ripple operations
  typedef enum logic [1:0] {
    PLS_ADD, PLS_SUB, PLS_DYN, PLS_MUL
  } pls_op_t;
  // register capture styles
  typedef enum logic [1:0] {
    PLS_POS, PLS_NEG, PLS_LATCH, PLS_NOCAP
  } pls_cap_t;
  // slice configuration word, field order gives bit positions
  typedef struct packed {
    logic [17:0] rsvd;
    logic counter;
    logic lsr_en;
    logic ce_sel;
    logic lsr_sel;
    logic clk_sel;
    logic [1:0] lsr_val;
    logic lsr_async;
    pls_cap_t cap;
    pls_op_t op;
    pls_mode_t mode;
  } pls_cfg_t;
  // thirteen routing inputs of one slice
  typedef struct packed {
    logic ce;
    logic lsr;
    logic clk;
    logic [1:0] m;
    logic [1:0] d;
    logic [1:0] c;
    logic [1:0] b;
    logic [1:0] a;
  } pls_in_t;
  // six routing outputs of one slice
  typedef struct packed {
    logic [1:0] ofx;
    logic [1:0] q;
    logic [1:0] f;
  } pls_out_t;
endpackage

//--- rtl/pls_table.sv
`timescale 1ns/1ps
// ----------------------------------------
// sixteen entry truth table / 16x1 memory
// ----------------------------------------
module pls_table
  import pls_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cfg_we_i,
  input wire logic [15:0] cfg_d_i,
  input wire logic ram_we_i,
  input wire logic [3:0] ram_adr_i,
  input wire logic ram_d_i,
  input wire logic [3:0] rd_adr_i,
  output logic [15:0] truth_o,
  output logic f_o
);
  // table contents
  logic [15:0] truth_r;

  // configuration load first, then memory writes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      truth_r <= PLS_TRUTH_RST;
    end
    else if (cfg_we_i)
    begin
      truth_r <= cfg_d_i;
    end
    else if (ram_we_i)
    begin
      truth_r[ram_adr_i] <= ram_d_i;
    end
  end

  // combinational lookup
  assign f_o = truth_r[rd_adr_i];
  assign truth_o = truth_r;
endmodule

//--- rtl/pls_sreg.sv
`timescale 1ns/1ps
// ----------------------------------------
// slice storage register
// ----------------------------------------
module pls_sreg
  import pls_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic rise_i,
  input wire logic fall_i,
  input wire logic lvl_i,
  input wire pls_cap_t cap_i,
  input wire logic ce_i,
  input wire logic lsr_i,
  input wire logic async_i,
  input wire logic lsr_val_i,
  input wire logic d_i,
  output logic q_o
);
  logic q_r; // held value
  logic cap_w; // capture event
  logic open_w; // latch transparent

  // capture event by style
  always_comb
  begin
    case (cap_i)
      PLS_POS: cap_w = rise_i;
      PLS_NEG: cap_w = fall_i;
      PLS_LATCH: cap_w = lvl_i;
      default: cap_w = 1'b0;
    endcase
  end

  // set/reset wins over data
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q_r <= 1'b0;
    end
    else if (lsr_i && async_i)
    begin
      q_r <= lsr_val_i;
    end
    else if (cap_w && lsr_i)
    begin
      q_r <= lsr_val_i;
    end
    else if (cap_w && ce_i)
    begin
      q_r <= d_i;
    end
  end

  // transparent while latch is open
  assign open_w = (cap_i == PLS_LATCH) && lvl_i && ce_i && !lsr_i;
  // async set/reset forces output at once
  assign q_o = (lsr_i && async_i) ? lsr_val_i :
               open_w ? d_i : q_r;
endmodule

//--- bench/pls_fabric.sv
`timescale 1ns/1ps
// ----------------------------------------
// routing fabric around one unit
// ----------------------------------------
module pls_fabric
  import pls_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pls_in_t [3:0] val_i,
  input wire logic [3:0] tick_i,
  input wire logic [7:0] len_i,
  output pls_in_t [3:0] route_o
);
  logic [7:0] cnt_r; // cycles left in the pulse
  logic [3:0] hi_r; // slice clocks, still between pulses
  // one routing clock pulse per request, short or long
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cnt_r <= 8'h00;
      hi_r <= 4'h0;
    end
    else if (cnt_r != 8'h00)
      cnt_r <= cnt_r - 8'h01;
    else if (tick_i != 4'h0)
    begin
      cnt_r <= len_i;
      hi_r <= tick_i;
    end
    else
      hi_r <= 4'h0;
  end
  // routing signals pass, slice clocks come from the pulser
  always_comb
  begin
    route_o = val_i;
    for (int s = 0; s < 4; s++)
      route_o[s].clk = hi_r[s];
  end
endmodule

//--- bench/pls_unit_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checks of the unit
// ----------------------------------------
module pls_unit_sva
  import pls_pkg::*;
#(
  parameter bit RAM_CAPABLE = 1'b1
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire pls_in_t [3:0] route_i,
  input wire logic carry_in_i,
  input wire logic wide_i,
  input wire pls_out_t [3:0] route_o,
  input wire logic carry_out_o,
  input wire logic seven_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_ack_follows_req: assert property (
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack after a taken request");
  a_ack_one_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (
    wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
    else $error("ack without request");
  a_ack_within: assert property (
    (wb_cyc_i && wb_stb_i) |-> ##[0:1] wb_ack_o)
    else $error("request left unanswered");
  a_reset_clears: assert property (
    $fell(rst_i) |-> !wb_ack_o && (wb_dat_o == 32'h0))
    else $error("bus outputs not cleared by reset");
  a_read_data_holds: assert property (
    !(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o) |=> $stable(wb_dat_o))
    else $error("read data moved without a read");
  a_slice3_no_regs: assert property (
    route_o[3].q == 2'h0)
    else $error("slice three shows stored bits");
  a_five_input_join: assert property (
    route_o[3].ofx[0] ==
      (route_i[3].m[0] ? route_o[3].f[1] : route_o[3].f[0]))
    else $error("wide select output wrong");
endmodule

bind pls_unit pls_unit_sva #(.RAM_CAPABLE(RAM_CAPABLE)) i_sva (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .route_i(route_i), .carry_in_i(carry_in_i), .wide_i(wide_i),
  .route_o(route_o), .carry_out_o(carry_out_o), .seven_o(seven_o));

//--- bench/tb_pls_unit.sv
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; $display("unexpected at %0t: got %h want %h", \
  $time, g, e); end end
module tb_pls_unit
  import pls_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0; // bus master signals
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dw = 32'h0;
  logic [31:0] wb_dr;
  logic wb_ack;
  pls_in_t [3:0] rv = '0; // routing values asked of the fabric
  pls_in_t [3:0] route;
  pls_out_t [3:0] ro;
  logic cin = 1'b0;
  logic wide = 1'b0;
  logic cout; // fast carry out of the chain
  logic sev; // seven input join result
  logic [3:0] tick = 4'h0;
  logic [7:0] len = 8'h00;
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic [31:0] msk_q[$];
  logic [31:0] me, mm;
  logic [31:0] tt[4]; // truth contents per slice
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  integer seed = 81;
  always #2.5 clk_i = ~clk_i;
  pls_unit i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dw), .wb_dat_o(wb_dr), .wb_ack_o(wb_ack),
    .route_i(route), .carry_in_i(cin), .wide_i(wide), .route_o(ro),
    .carry_out_o(cout), .seven_o(sev));
  pls_fabric i_fab (.clk_i(clk_i), .rst_i(rst_i), .val_i(rv),
    .tick_i(tick), .len_i(len), .route_o(route));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // one classic cycle; d is write data or the expected read value
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [31:0] m);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dw <= d;
    if (!w)
    begin
      exp_q.push_back(d);
      msk_q.push_back(m);
    end
    @(posedge clk_i);
    while (wb_ack !== 1'b1)
      @(posedge clk_i);
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_i);
  endtask
  // one routing clock pulse on slice 0, then a wait
  task automatic pulse(input logic [7:0] l, input int n);
    tick <= 4'h1;
    len <= l;
    @(posedge clk_i);
    tick <= 4'h0;
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [7:0] loc(input int s, input logic [7:0] o);
    return 8'(s * 16) + o;
  endfunction
  function automatic logic [1:0] lut(input logic [31:0] t, input pls_in_t v);
    lut[0] = t[{v.d[0], v.c[0], v.b[0], v.a[0]}];
    lut[1] = t[16 + {v.d[1], v.c[1], v.b[1], v.a[1]}];
  endfunction
  // read results compared against the oldest note
  always @(posedge clk_i)
  begin
    if (wb_ack === 1'b1 && wb_we === 1'b0 && exp_q.size() > 0)
    begin
      me = exp_q.pop_front();
      mm = msk_q.pop_front();
      `CHK(wb_dr & mm, me & mm)
    end
  end
  // hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      conclude();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    pls_cfg_t c;
    pls_in_t v, w0;
    logic [2:0] s3;
    logic [1:0] f, rd2;
    logic [3:0] ra;
    logic add;
    logic x7; // expected six input join of slices 0/1
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      wb(1'b0, loc(s, PLS_OFS_TRUTH), 32'h0, '1);
      wb(1'b0, loc(s, PLS_OFS_CFG), PLS_CFG_RST, '1);
    end
    wb(1'b0, PLS_OFS_UNIT, 32'h0, '1);
    wb(1'b1, 8'h0C, '1, 32'h0);
    wb(1'b0, 8'h0C, 32'h0, '1);
    $display("test reset done");
    // logic mode: every slice, random tables and inputs
    for (int s = 0; s < 4; s++)
    begin
      tt[s] = $random(seed);
      wb(1'b1, loc(s, PLS_OFS_TRUTH), tt[s], 32'h0);
      wb(1'b0, loc(s, PLS_OFS_TRUTH), tt[s], '1);
      repeat (4)
      begin
        v = 13'($random(seed));
        rv[s] <= v;
        wide <= 1'($random(seed));
        f = lut(tt[s], v);
        wb(1'b0, loc(s, PLS_OFS_STAT), {27'h0, v.m[0] ? f[1] : f[0],
           2'h0, f}, 32'h1F);
        // slices 2/3 still hold empty tables, so their join is zero
        if (s == 1)
        begin
          rd2 = lut(tt[0], rv[0]);
          x7 = rv[0].m[1] ? (v.m[0] ? f[1] : f[0]) :
               (rv[0].m[0] ? rd2[1] : rd2[0]);
          `CHK(sev, v.m[1] ? 1'b0 : x7)
        end
      end
    end
    $display("test logic done");
    // ripple: add, subtract and run-time choice in slice 0
    c = '0;
    c.mode = PLS_RIPPLE;
    // slices 1 and 2 add 3 + 0, so they pass the carry straight on
    w0 = '0;
    w0.a = 2'h3;
    rv[1] <= w0;
    rv[2] <= w0;
    wb(1'b1, loc(1, PLS_OFS_CFG), c, 32'h0);
    wb(1'b1, loc(2, PLS_OFS_CFG), c, 32'h0);
    for (int op = 0; op < 3; op++)
    begin
      c.op = pls_op_t'(op);
      wb(1'b1, loc(0, PLS_OFS_CFG), c, 32'h0);
      repeat (6)
      begin
        v = 13'($random(seed));
        rd2 = 2'($random(seed));
        rv[0] <= v;
        cin <= rd2[0];
        add = (op == 0) || (op == 2 && v.d[0]);
        s3 = {1'b0, v.a} + {1'b0, add ? v.b : ~v.b} + {2'h0, rd2[0]};
        wb(1'b0, loc(0, PLS_OFS_STAT), {22'h0, v.a != v.b, v.a <= v.b,
           v.a >= v.b, s3[2], v.a <= v.b, v.a >= v.b, 2'h0, s3[1:0]},
           32'h3F3);
        `CHK(cout, s3[2])
      end
    end
    $display("test ripple done");
    // memory: slice 1 gives address and write, slice 0 stores
    c = '0;
    c.mode = PLS_RAM;
    wb(1'b1, loc(0, PLS_OFS_CFG), c, 32'h0);
    wb(1'b1, loc(1, PLS_OFS_CFG), 32'h0, 32'h0);
    rv <= '0;
    repeat (4)
    begin
      ra = 4'($random(seed));
      rd2 = 2'($random(seed));
      v = '0;
      {v.d[0], v.c[0], v.b[0], v.a[0]} = ra;
      v.m[0] = 1'b1;
      w0 = '0;
      w0.a = {2{ra[0]}};
      w0.b = {2{ra[1]}};
      w0.c = {2{ra[2]}};
      w0.d = {2{ra[3]}};
      w0.m = rd2;
      rv[1] <= v;
      rv[0] <= w0;
      @(posedge clk_i);
      rv[1] <= '0;
      tt[0][ra] = rd2[0];
      tt[0][16 + ra] = rd2[1];
      wb(1'b0, loc(0, PLS_OFS_TRUTH), tt[0], '1);
      wb(1'b0, loc(0, PLS_OFS_STAT), {30'h0, rd2}, 32'h3);
    end
    $display("test memory done");
    // storage register: rising then falling capture
    wb(1'b1, loc(0, PLS_OFS_TRUTH), '1, 32'h0);
    c = '0;
    c.clk_sel = 1'b1;
    c.cap = PLS_POS;
    wb(1'b1, loc(0, PLS_OFS_CFG), c, 32'h0);
    pulse(8'h04, 12);
    wb(1'b0, loc(0, PLS_OFS_STAT), 32'hC, 32'hC);
    wb(1'b1, loc(0, PLS_OFS_TRUTH), 32'h0, 32'h0);
    c.cap = PLS_NEG;
    wb(1'b1, loc(0, PLS_OFS_CFG), c, 32'h0);
    pulse(8'h14, 8);
    wb(1'b0, loc(0, PLS_OFS_STAT), 32'hC, 32'hC);
    repeat (20) @(posedge clk_i);
    wb(1'b0, loc(0, PLS_OFS_STAT), 32'h0, 32'hC);
    $display("test capture done");
    // set and reset: async at once, sync only at a capture
    c.lsr_en = 1'b1;
    c.lsr_async = 1'b1;
    c.lsr_val = 2'h3;
    wb(1'b1, loc(0, PLS_OFS_CFG), c, 32'h0);
    wb(1'b0, loc(0, PLS_OFS_STAT), 32'hC, 32'hC);
    wb(1'b1, loc(0, PLS_OFS_TRUTH), '1, 32'h0);
    c.lsr_async = 1'b0;
    c.lsr_val = 2'h0;
    wb(1'b1, loc(0, PLS_OFS_CFG), c, 32'h0);
    wb(1'b0, loc(0, PLS_OFS_STAT), 32'hC, 32'hC);
    pulse(8'h04, 14);
    wb(1'b0, loc(0, PLS_OFS_STAT), 32'h0, 32'hC);
    $display("test set reset done");
    conclude();
  end
endmodule
